/* design/rtc_core.sv */
// Status/interrupt register, seconds..days timekeeping, month/year/century.
// Assumes a register front end on clk_sys and a free-running timebase clock.
//
// Overview of operation
// R1 - Control bits 7..5 read zero by default
// R2 - Level mode: interrupt follows countdown flag and enable
// R3 - Pulse mode: one pulse per countdown event
// R4 - Pulse width set by source clock and n
// R5 - Pulse mode: alarm flag with enable holds interrupt
// R6 - Alarm match sets bit 3; countdown sets bit 2
// R7 - Flags stay set until software clears them
// R8 - Flag write stores AND of written and current
// R9 - Interrupt is OR of gated alarm and countdown
// R10 - Countdown flag and interrupt rise together
// R11 - Zero reload value raises no countdown events
// R12 - Seconds bit 7 reports clock integrity lost
// R13 - Seconds in BCD bits 6..0, 00 to 59
// R14 - Minutes in BCD bits 6..0, 00 to 59
// R15 - Hours in BCD bits 5..0, 00 to 23
// R16 - Days in BCD bits 5..0, 01 to 31
// R17 - February gets 29 days when year divisible by four
// R18 - Alarm flag set when enabled fields first match
// R19 - Century bit toggles when year wraps 99 to 00
// R20 - Month BCD 01 to 12, advances past month end
// R21 - One-second tick carries seconds through days
// R22 - Unimplemented bits read zero, ignore writes
`include "rtc_params.svh"

module rtc_core
    import rtc_pkg::*;
#(
    parameter int XTAL_DIV = `RTC_XTAL_DIV,
    parameter int PW_8192 = `RTC_PW_8192_CYC,
    parameter int PW_4096 = `RTC_PW_4096_CYC,
    parameter int PW_128 = `RTC_PW_128_CYC,
    parameter int PW_64 = `RTC_PW_64_CYC
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic clk_xtal, // Timebase clock, second domain
    input wire rtc_wreq_t wreq, // Register write request
    input wire logic [7:0] rd_addr, // Register read address
    output logic [7:0] rd_data, // Read data, registered
    input wire rtc_alarm_t alarm, // Alarm compare fields
    input wire logic [2:0] wday, // Current weekday
    input wire rtc_timer_t timer, // Countdown status
    output logic [4:0] month, // Month, BCD
    output logic [7:0] year, // Year, BCD
    output logic century, // Century bit
    output logic int_level, // Interrupt pin level while driven, always low
    output logic int_oe // Interrupt pin driven low while asserted
);
    // =============================================================
    // Elaboration checks
    if (XTAL_DIV < 2 || XTAL_DIV > 65536) begin : g_chk_div
        $error("XTAL_DIV must be 2 to 65536");
    end
    if (PW_8192 < 1 || PW_64 >= (1 << 21)) begin : g_chk_pw
        $error("Pulse widths must be 1 to 2**21-1 cycles");
    end

    // =============================================================
    // Functions
    // BCD increment with wrap: returns {carry, next}
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] first);
        logic [7:0] n;
        n = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
        if (v == top) begin
            bcd_inc = {1'b1, first};
        end else begin
            bcd_inc = {1'b0, n};
        end
    endfunction : bcd_inc

    // Last day of a month in BCD
    function automatic logic [7:0] month_len(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 5'h02) begin
            month_len = leap ? 8'h29 : 8'h28; // R17
        end else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) begin
            month_len = 8'h30;
        end else begin
            month_len = 8'h31;
        end
    endfunction : month_len

    // Pulse width in system cycles
    function automatic logic [20:0] pulse_len(input logic [1:0] src, input logic n_one);
        if (src == 2'd0) begin
            pulse_len = n_one ? 21'(PW_8192) : 21'(PW_4096);
        end else if (src == 2'd1) begin
            pulse_len = n_one ? 21'(PW_128) : 21'(PW_64);
        end else begin
            pulse_len = 21'(PW_64);
        end
    endfunction : pulse_len

    // =============================================================
    // Timebase domain: divide to one-second toggle
    logic [15:0] div_q;
    logic tick_tgl_q;

    // Toggle, not pulse, so the slow-to-fast crossing cannot miss an event
    always_ff @(posedge clk_xtal or negedge nrst) begin
        if (!nrst) begin
            div_q <= 16'h0000;
            tick_tgl_q <= 1'b0;
        end else if (div_q == 16'(XTAL_DIV - 1)) begin
            div_q <= 16'h0000;
            tick_tgl_q <= ~tick_tgl_q;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // =============================================================
    // Crossing: three flops; a change counts once stages two and three agree
    logic sync1_q, sync2_q, sync3_q;
    logic tick_seen_q;
    wire sync_agree = (sync2_q == sync3_q);
    // Waiting for agreement rejects a single unsettled sample
    wire sec_tick = sync_agree && (sync3_q != tick_seen_q);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            tick_seen_q <= 1'b0;
        end else begin
            sync1_q <= tick_tgl_q;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            tick_seen_q <= sync_agree ? sync3_q : tick_seen_q;
        end
    end

    // =============================================================
    // Register state
    logic mode_q, alarm_flag_q, countdown_flag_q;
    logic alarm_irq_enable_q, countdown_irq_enable_q;
    logic clock_integrity_lost_q;
    logic [6:0] sec_q, min_q;
    logic [5:0] hour_q, day_q;
    logic [4:0] mon_q;
    logic [7:0] year_q;
    logic cent_q;
    logic match_q;

    // Write decode
    wire wr_ctrl = wreq.wr && (wreq.addr == `RTC_OFS_CTRL2);
    wire wr_sec = wreq.wr && (wreq.addr == `RTC_OFS_SEC);
    wire wr_min = wreq.wr && (wreq.addr == `RTC_OFS_MIN);
    wire wr_hour = wreq.wr && (wreq.addr == `RTC_OFS_HOUR);
    wire wr_day = wreq.wr && (wreq.addr == `RTC_OFS_DAY);

    // =============================================================
    // Timekeeping carry chain
    wire [8:0] sec_n = bcd_inc({1'b0, sec_q}, 8'h59, 8'h00); // R13 R21
    wire [8:0] min_n = bcd_inc({1'b0, min_q}, 8'h59, 8'h00); // R14
    wire [8:0] hour_n = bcd_inc({2'b00, hour_q}, 8'h23, 8'h00); // R15
    wire [8:0] day_n = bcd_inc({2'b00, day_q}, month_len(mon_q, year_q), 8'h01); // R16
    wire [8:0] mon_n = bcd_inc({3'b000, mon_q}, 8'h12, 8'h01); // R20
    wire [8:0] year_n = bcd_inc(year_q, 8'h99, 8'h00);
    wire c_sec = sec_tick;
    wire c_min = c_sec && sec_n[8];
    wire c_hour = c_min && min_n[8];
    wire c_day = c_hour && hour_n[8];
    wire c_mon = c_day && day_n[8];
    wire c_year = c_mon && mon_n[8];

    // Software writes take priority over the tick in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sec_q <= `RTC_RST_SEC;
            min_q <= `RTC_RST_MIN;
            hour_q <= `RTC_RST_HOUR;
            day_q <= `RTC_RST_DAY;
        end else begin
            sec_q <= wr_sec ? wreq.data[6:0] : (c_sec ? sec_n[6:0] : sec_q);
            min_q <= wr_min ? wreq.data[6:0] : (c_min ? min_n[6:0] : min_q); // R22
            hour_q <= wr_hour ? wreq.data[5:0] : (c_hour ? hour_n[5:0] : hour_q);
            day_q <= wr_day ? wreq.data[5:0] : (c_day ? day_n[5:0] : day_q);
        end
    end

    // Month, year and century advance only through the carry chain
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mon_q <= `RTC_RST_MONTH;
            year_q <= `RTC_RST_YEAR;
            cent_q <= 1'b0;
        end else begin
            mon_q <= c_mon ? mon_n[4:0] : mon_q; // R20
            year_q <= c_year ? year_n[7:0] : year_q;
            cent_q <= cent_q ^ (c_year && year_n[8]); // R19
        end
    end

    // Integrity flag: set at power-on, only software clears it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clock_integrity_lost_q <= `RTC_RST_INTEG;
        end else if (wr_sec) begin
            clock_integrity_lost_q <= wreq.data[`RTC_BIT_INTEG]; // R12
        end
    end

    // =============================================================
    // Alarm compare: only enabled fields, at least one enabled
    wire any_en = !(alarm.min_dis && alarm.hour_dis && alarm.day_dis && alarm.wday_dis);
    wire match_now = any_en
        && (alarm.min_dis || alarm.min == min_q)
        && (alarm.hour_dis || alarm.hour == hour_q)
        && (alarm.day_dis || alarm.day == day_q)
        && (alarm.wday_dis || alarm.wday == wday);
    wire alarm_flag_set = match_now && !match_q; // R18
    wire countdown_flag_set = timer.done && (timer.reload != 8'h00); // R11

    // Flags: write ANDs, a same-cycle event wins over the clear
    wire alarm_flag_d = (wr_ctrl ? (alarm_flag_q & wreq.data[`RTC_BIT_ALARM])
                                 : alarm_flag_q) | alarm_flag_set; // R6 R7 R8
    wire countdown_flag_d = (wr_ctrl ? (countdown_flag_q & wreq.data[`RTC_BIT_CNTDN])
                                     : countdown_flag_q) | countdown_flag_set; // R6 R7 R8

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            alarm_flag_q <= 1'(`RTC_RST_CTRL2 >> `RTC_BIT_ALARM);
            countdown_flag_q <= 1'(`RTC_RST_CTRL2 >> `RTC_BIT_CNTDN);
            match_q <= 1'b0;
        end else begin
            alarm_flag_q <= alarm_flag_d;
            countdown_flag_q <= countdown_flag_d;
            match_q <= match_now;
        end
    end

    // Control bits; bits 7..5 are not stored
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_q <= 1'(`RTC_RST_CTRL2 >> `RTC_BIT_MODE);
            alarm_irq_enable_q <= 1'(`RTC_RST_CTRL2 >> `RTC_BIT_ALARM_IE);
            countdown_irq_enable_q <= 1'(`RTC_RST_CTRL2 >> `RTC_BIT_CNTDN_IE);
        end else if (wr_ctrl) begin
            mode_q <= wreq.data[`RTC_BIT_MODE];
            alarm_irq_enable_q <= wreq.data[`RTC_BIT_ALARM_IE];
            countdown_irq_enable_q <= wreq.data[`RTC_BIT_CNTDN_IE];
        end
    end

    // =============================================================
    // Pulse-mode interrupt generator
    rtc_pstate_t pst_q, pst_d;
    logic [20:0] pcnt_q, pcnt_d;
    wire pulse_start = countdown_flag_set && countdown_irq_enable_q && mode_q; // R3

    // A new event during a pulse restarts the width rather than being lost
    always_comb begin
        pst_d = pst_q;
        pcnt_d = pcnt_q;
        case (pst_q)
            RTC_PS_IDLE: begin
                if (pulse_start) begin
                    pst_d = RTC_PS_PULSE;
                    pcnt_d = pulse_len(timer.src, timer.reload == 8'h01); // R4
                end
            end
            RTC_PS_PULSE: begin
                if (pulse_start) begin
                    pcnt_d = pulse_len(timer.src, timer.reload == 8'h01);
                end else if (pcnt_q == 21'd1) begin
                    pst_d = RTC_PS_IDLE;
                    pcnt_d = 21'd0;
                end else begin
                    pcnt_d = pcnt_q - 21'd1;
                end
            end
            default: begin
                pst_d = RTC_PS_IDLE;
                pcnt_d = 21'd0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pst_q <= RTC_PS_IDLE;
            pcnt_q <= 21'd0;
        end else begin
            pst_q <= pst_d;
            pcnt_q <= pcnt_d;
        end
    end

    // =============================================================
    // Interrupt request; pulse state enables in the same edge as the flag
    // The enable gates pulse mode too, so clearing it cuts a running pulse short
    wire pulse_on = (pst_q == RTC_PS_PULSE) && countdown_irq_enable_q;
    wire level_on = countdown_flag_q && countdown_irq_enable_q; // R2
    wire tmr_irq = mode_q ? pulse_on : level_on; // R3 R10
    wire alm_irq = alarm_flag_q && alarm_irq_enable_q; // R5
    assign int_oe = tmr_irq || alm_irq; // R9
    assign int_level = 1'b0;

    // =============================================================
    // Read path, registered; unmapped and unimplemented bits read zero
    wire [7:0] ctrl_rd = {3'b000, mode_q, alarm_flag_q, countdown_flag_q,
                          alarm_irq_enable_q, countdown_irq_enable_q}; // R1 R22
    wire [7:0] rd_d = (rd_addr == `RTC_OFS_CTRL2) ? ctrl_rd
                    : (rd_addr == `RTC_OFS_SEC) ? {clock_integrity_lost_q, sec_q}
                    : (rd_addr == `RTC_OFS_MIN) ? {1'b0, min_q}
                    : (rd_addr == `RTC_OFS_HOUR) ? {2'b00, hour_q}
                    : (rd_addr == `RTC_OFS_DAY) ? {2'b00, day_q}
                    : 8'h00;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_d;
        end
    end
    assign month = mon_q;
    assign year = year_q;
    assign century = cent_q;

    // =============================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    ctrl_upper_zero_a : assert property ((rd_addr == `RTC_OFS_CTRL2) |=> rd_data[7:5] == 3'b000) // R1
        else $error("upper control bits not zero");
    level_irq_a : assert property (!mode_q && countdown_flag_q && countdown_irq_enable_q // R2
                                   |-> int_oe)
        else $error("level interrupt missing");
    pulse_end_a : assert property (mode_q && !alarm_irq_enable_q // R3
                                   && $fell(pst_q == RTC_PS_PULSE) |-> !int_oe)
        else $error("pulse did not end");
    pulse_width_a : assert property (pulse_start && timer.src == 2'd2 && !wr_ctrl // R4
                                     |=> pcnt_q == 21'(PW_64))
        else $error("pulse width wrong");
    alarm_hold_a : assert property (alarm_flag_q && alarm_irq_enable_q |-> int_oe) // R5
        else $error("alarm interrupt dropped");
    flag_sticky_a : assert property (countdown_flag_q && !wr_ctrl |=> countdown_flag_q) // R7
        else $error("countdown flag lost without write");
    flag_and_a : assert property (wr_ctrl && !alarm_flag_set // R8
                                  && !wreq.data[`RTC_BIT_ALARM] |=> !alarm_flag_q)
        else $error("alarm flag not cleared");
    irq_mask_a : assert property (!alarm_irq_enable_q && !countdown_irq_enable_q // R9
                                  |-> !int_oe)
        else $error("masked interrupt asserted");
    same_edge_a : assert property (countdown_flag_set && !countdown_flag_q // R10
                                   && countdown_irq_enable_q |=> countdown_flag_q && int_oe)
        else $error("flag and interrupt not together");
    zero_reload_a : assert property (timer.done && timer.reload == 8'h00 // R11
                                     && !countdown_flag_q && !wr_ctrl |=> !countdown_flag_q)
        else $error("zero reload raised event");
    integ_write_a : assert property (wr_sec // R12
                                     |=> clock_integrity_lost_q == $past(wreq.data[7]))
        else $error("integrity bit not written");
    sec_range_a : assert property (c_sec && !wr_sec && sec_q == 7'h59
                                   |=> sec_q == 7'h00) // R13
        else $error("seconds did not wrap");
    min_wrap_a : assert property (c_min && !wr_min && min_q == 7'h59 |=> min_q == 7'h00) // R14
        else $error("minutes did not wrap");
    hour_wrap_a : assert property (c_hour && !wr_hour && hour_q == 6'h23 // R15
                                   |=> hour_q == 6'h00)
        else $error("hours did not wrap");
    sec_advance_a : assert property (c_sec && !wr_sec |=> sec_q != $past(sec_q)) // R21
        else $error("seconds did not advance on tick");
    alarm_set_a : assert property (alarm_flag_set |=> alarm_flag_q) // R18
        else $error("alarm flag not set");
    century_a : assert property (c_year && year_q == 8'h99 |=> century != $past(century)) // R19
        else $error("century not toggled");

    cov_pulse_c : cover property (pulse_start ##1 (pst_q == RTC_PS_PULSE));
    cov_alarm_c : cover property (alarm_flag_set ##1 int_oe);
    cov_day_c : cover property (c_mon);
    cov_clear_c : cover property (wr_ctrl && countdown_flag_q ##1 !countdown_flag_q);
endmodule : rtc_core

/* inc/rtc_params.svh */
// Constants for the clock status, interrupt and timekeeping block.
// Assumes a 100 MHz system clock and a 32.768 kHz timebase clock.
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// =============================================================
// Register offsets
`define RTC_OFS_CTRL2 8'h01
`define RTC_OFS_SEC 8'h02
`define RTC_OFS_MIN 8'h03
`define RTC_OFS_HOUR 8'h04
`define RTC_OFS_DAY 8'h05
// =============================================================
// Control/status two field positions, and the seconds integrity bit
`define RTC_BIT_MODE 4
`define RTC_BIT_ALARM 3
`define RTC_BIT_CNTDN 2
`define RTC_BIT_ALARM_IE 1
`define RTC_BIT_CNTDN_IE 0
`define RTC_BIT_INTEG 7
// =============================================================
// Reset values
`define RTC_RST_CTRL2 8'h00
`define RTC_RST_SEC 7'h00
`define RTC_RST_INTEG 1'b1
`define RTC_RST_MIN 7'h00
`define RTC_RST_HOUR 6'h00
`define RTC_RST_DAY 6'h01
`define RTC_RST_MONTH 5'h01
`define RTC_RST_YEAR 8'h00
// =============================================================
// Timing: system rate, timebase divide, pulse widths as fractions of a second
`define RTC_SYS_HZ 100000000
`define RTC_XTAL_DIV 32768
`define RTC_PW_8192_DEN 8192
`define RTC_PW_4096_DEN 4096
`define RTC_PW_128_DEN 128
`define RTC_PW_64_DEN 64
`define RTC_PW_8192_CYC (`RTC_SYS_HZ / `RTC_PW_8192_DEN)
`define RTC_PW_4096_CYC (`RTC_SYS_HZ / `RTC_PW_4096_DEN)
`define RTC_PW_128_CYC (`RTC_SYS_HZ / `RTC_PW_128_DEN)
`define RTC_PW_64_CYC (`RTC_SYS_HZ / `RTC_PW_64_DEN)
`endif

/* inc/rtc_pkg.sv */
// Types shared by the clock status, interrupt and timekeeping block.
// Assumes nothing beyond a SystemVerilog compiler.
package rtc_pkg;
    // =============================================================
    // Register write request from the serial-bus front end
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } rtc_wreq_t;
    // Alarm compare fields, each with its disable bit
    typedef struct packed {
        logic min_dis;
        logic [6:0] min;
        logic hour_dis;
        logic [5:0] hour;
        logic day_dis;
        logic [5:0] day;
        logic wday_dis;
        logic [2:0] wday;
    } rtc_alarm_t;
    // Countdown timer status; source 0=4096 Hz 1=64 Hz 2=1 Hz 3=1/60 Hz
    typedef struct packed {
        logic done;
        logic [1:0] src;
        logic [7:0] reload;
    } rtc_timer_t;
    // Pulse-mode interrupt state
    typedef enum logic [1:0] {
        RTC_PS_IDLE = 2'b01,
        RTC_PS_PULSE = 2'b10
    } rtc_pstate_t;
endpackage : rtc_pkg

/* tb/rtc_tmr_model.sv */
// Stand-in for the countdown timer unit that feeds the status block.
// Assumes the bench raises fire for one clk_sys cycle per wanted event.
module rtc_tmr_model
    import rtc_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic fire, // Request one countdown completion
    input wire logic [1:0] src, // Source clock select
    input wire logic [7:0] reload, // Loaded reload value n
    output rtc_timer_t timer // Status seen by the block
);
    timeunit 1ns;
    timeprecision 100ps;
    // =============================================================
    // Completion strobe
    logic done_q;
    logic done_d;

    // Never two strobes in a row, as a real countdown needs time to run
    assign done_d = fire && !done_q;

    // One registered cycle per request
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    assign timer = '{done: done_q, src: src, reload: reload};
endmodule : rtc_tmr_model

/* tb/rtc_status_irq_and_time_regs_tb.sv */
// Self-checking bench for the status, interrupt and timekeeping block.
// Assumes shortened timebase and pulse counts set at the instance below.
module rtc_status_irq_and_time_regs_tb
    import rtc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    // =============================================================
    // Signals
    logic clk_sys, nrst, clk_xtal, xtal_run, fire, int_level, int_oe, century;
    logic [1:0] src;
    logic [7:0] reload, rd_addr, rd_data, year;
    logic [4:0] month;
    logic [2:0] wday;
    rtc_wreq_t wreq;
    rtc_alarm_t alarm;
    rtc_timer_t timer;
    int n_errors = 0;
    int comparisons = 0;

    rtc_core #(.XTAL_DIV(4), .PW_8192(3), .PW_4096(5), .PW_128(7), .PW_64(9)) dut_u (
        .clk_sys(clk_sys), .nrst(nrst), .clk_xtal(clk_xtal), .wreq(wreq),
        .rd_addr(rd_addr), .rd_data(rd_data), .alarm(alarm), .wday(wday),
        .timer(timer), .month(month), .year(year), .century(century),
        .int_level(int_level), .int_oe(int_oe));

    rtc_tmr_model tmr_u (.clk_sys(clk_sys), .nrst(nrst), .fire(fire), .src(src),
        .reload(reload), .timer(timer));

    // =============================================================
    // Clocks; the timebase is gated so register checks never race a tick
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_xtal = 1'b0;
        #17.3;
        forever begin
            #62.5;
            if (xtal_run) clk_xtal = ~clk_xtal;
        end
    end

    // =============================================================
    // Compare, bus and stimulus tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        wreq = '{wr: 1'b1, addr: a, data: d};
        @(negedge clk_sys);
        wreq.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        rd_addr = a;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        d = rd_data;
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk8(d, exp);
    endtask : rd_chk
    // Lets the timebase run until the seconds field moves, then halts it
    task automatic tick_once();
        logic [7:0] s0, s;
        rd(8'h02, s0);
        s = s0;
        xtal_run = 1'b1;
        for (int i = 0; i < 300 && s[6:0] === s0[6:0]; i++) rd(8'h02, s);
        xtal_run = 1'b0;
        chk1(s[6:0] !== s0[6:0], 1'b1);
    endtask : tick_once
    task automatic fire_evt(input logic [1:0] s, input logic [7:0] n);
        @(negedge clk_sys);
        src = s;
        reload = n;
        fire = 1'b1;
        @(negedge clk_sys);
        fire = 1'b0;
    endtask : fire_evt
    task automatic set_eod(input logic [7:0] day);
        wr(8'h02, 8'h59);
        wr(8'h03, 8'h59);
        wr(8'h04, 8'h23);
        wr(8'h05, day);
    endtask : set_eod

    // =============================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h80);
        rd_chk(8'h03, 8'h00);
        rd_chk(8'h04, 8'h00);
        rd_chk(8'h05, 8'h01);
        rd_chk(8'h06, 8'h00);
        chk8({3'h0, month}, 8'h01);
        chk8(year, 8'h00);
        chk1(century, 1'b0);
        chk1(int_oe, 1'b0);
        chk1(int_level, 1'b0);
    endtask : t_reset
    task automatic t_regs();
        wr(8'h02, 8'h45);
        rd_chk(8'h02, 8'h45);
        wr(8'h03, 8'hd9);
        rd_chk(8'h03, 8'h59);
        wr(8'h04, 8'he3);
        rd_chk(8'h04, 8'h23);
        wr(8'h05, 8'hf1);
        rd_chk(8'h05, 8'h31);
        wr(8'h01, 8'hef);
        rd_chk(8'h01, 8'h03);
        wr(8'h01, 8'h00);
    endtask : t_regs
    // Last second of 31 January, then 28 and 29 February of a leap year
    task automatic t_calendar();
        set_eod(8'h31);
        tick_once();
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h03, 8'h00);
        rd_chk(8'h04, 8'h00);
        rd_chk(8'h05, 8'h01);
        chk8({3'h0, month}, 8'h02);
        set_eod(8'h28);
        tick_once();
        rd_chk(8'h05, 8'h29);
        set_eod(8'h29);
        tick_once();
        rd_chk(8'h05, 8'h01);
        chk8({3'h0, month}, 8'h03);
        set_eod(8'h31);
        tick_once();
        chk8({3'h0, month}, 8'h04);
        set_eod(8'h30);
        tick_once();
        rd_chk(8'h05, 8'h01);
        chk8({3'h0, month}, 8'h05);
    endtask : t_calendar
    task automatic t_level();
        wr(8'h01, 8'h01);
        fire_evt(2'h0, 8'h05);
        @(negedge clk_sys);
        chk1(int_oe, 1'b1);
        rd_chk(8'h01, 8'h05);
        repeat (20) @(negedge clk_sys);
        chk1(int_oe, 1'b1);
        wr(8'h01, 8'h05);
        rd_chk(8'h01, 8'h05);
        wr(8'h01, 8'h01);
        rd_chk(8'h01, 8'h01);
        chk1(int_oe, 1'b0);
        wr(8'h01, 8'h00);
        fire_evt(2'h0, 8'h05);
        @(negedge clk_sys);
        chk1(int_oe, 1'b0);
        rd_chk(8'h01, 8'h04);
        wr(8'h01, 8'h01);
        fire_evt(2'h0, 8'h00);
        repeat (3) @(negedge clk_sys);
        rd_chk(8'h01, 8'h01);
        chk1(int_oe, 1'b0);
    endtask : t_level
    // Pulse width per source and reload value, in shortened counts
    task automatic t_pulse();
        logic [1:0] srcs [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
        logic [7:0] ns [6] = '{8'h01, 8'h02, 8'h01, 8'h03, 8'h01, 8'h04};
        logic [7:0] ws [6] = '{8'h03, 8'h05, 8'h07, 8'h09, 8'h09, 8'h09};
        logic [7:0] cnt;
        wr(8'h01, 8'h11);
        for (int i = 0; i < 6; i++) begin
            fire_evt(srcs[i], ns[i]);
            cnt = 8'h00;
            @(negedge clk_sys);
            while (int_oe === 1'b1 && cnt < 8'h32) begin
                cnt++;
                @(negedge clk_sys);
            end
            chk8(cnt, ws[i]);
            repeat (10) @(negedge clk_sys);
            chk1(int_oe, 1'b0);
        end
    endtask : t_pulse
    // Minute alarm on 01 while the time is 00:00:59
    task automatic t_alarm();
        wr(8'h01, 8'h12);
        alarm = '{min_dis: 1'b0, min: 7'h01, hour_dis: 1'b1, hour: 6'h00,
            day_dis: 1'b1, day: 6'h01, wday_dis: 1'b1, wday: 3'h0};
        wr(8'h02, 8'h59);
        rd_chk(8'h01, 8'h12);
        tick_once();
        repeat (5) @(negedge clk_sys);
        rd_chk(8'h01, 8'h1a);
        repeat (20) @(negedge clk_sys);
        chk1(int_oe, 1'b1);
        wr(8'h01, 8'h12);
        rd_chk(8'h01, 8'h12);
        chk1(int_oe, 1'b0);
    endtask : t_alarm

    // =============================================================
    // Verdict, main sequence and watchdog
    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        nrst = 1'b0;
        xtal_run = 1'b0;
        fire = 1'b0;
        src = 2'h0;
        reload = 8'h00;
        rd_addr = 8'h00;
        wday = 3'h0;
        wreq = '{wr: 1'b0, addr: 8'h00, data: 8'h00};
        alarm = '{min_dis: 1'b1, min: 7'h00, hour_dis: 1'b1, hour: 6'h00,
            day_dis: 1'b1, day: 6'h01, wday_dis: 1'b1, wday: 3'h0};
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        t_reset();
        t_regs();
        t_calendar();
        t_level();
        t_pulse();
        t_alarm();
        end_sim();
    end
    // Worst case is a few thousand cycles; this margin only catches a hang
    initial begin
        #800000;
        n_errors++;
        end_sim();
    end
endmodule : rtc_status_irq_and_time_regs_tb
